// ### edcp_device.sv
`timescale 1ns/1ns
`default_nettype none
module edcp_device #(
    parameter int P_MS_CYCLES = edcp_pkg::MS_CYCLES
)(
    input  wire logic                       i_clk,
    input  wire logic                       i_arst_n,
    edcp_link_if.device                     link,
    input  wire logic                       i_fault_cause,
    input  wire logic                       i_cap_charged,
    input  wire logic [7:0]                 i_dip_min_ms,
    input  wire logic                       i_repeat_on,
    input  wire logic                       i_output_done,
    input  wire logic                       i_lamp_flash,
    output logic                            o_hv_enable,
    output logic                            o_fire,
    output logic                            o_firing,
    output logic                            o_stop_output,
    output logic                            o_alarm,
    output logic                            o_guide_beam,
    output logic [1:0]                      o_beam_unit,
    output logic [edcp_pkg::SCH_W-1:0]      o_schedule,
    output logic                            o_main_power_cut,
    output logic                            o_shutter_close
);
    import edcp_pkg::*;

    typedef struct packed {
        logic [NIN-1:0]            s1;
        logic [NIN-1:0]            s2;
        logic [NIN-1:0]            deb;
        logic [NIN-1:0][DEB_W-1:0] dcnt;
        logic [1:0]                x1;
        logic [1:0]                x2;
        logic [DIV_W-1:0]          div;
        logic                      tick;
        logic                      hv;
        logic [11:0]               lock;
        logic                      alarm;
        logic [7:0]                close_ms;
        logic [5:0]                open_ms;
        logic                      fired;
        logic                      firing;
        logic                      fire_p;
        logic                      stop_p;
        logic [5:0]                end_ms;
        logic                      end_c;
        logic                      ready;
        logic                      accept;
        logic                      guide;
        logic [1:0]                beam;
        logic [SCH_W-1:0]          sch;
        logic                      pcut;
        logic                      shut;
    } edcp_dev_state_t;

    edcp_dev_state_t q;
    edcp_dev_state_t d;

    logic [NIN-1:0] raw;
    logic           rem;
    logic           fire_c;
    logic           stop_c;

    assign raw = {link.schedule_select, link.beam_select,
                  link.guide_request, link.stop_contact,
                  link.fire_request, link.fault_reset,
                  link.high_voltage_request, link.remote_enable_input};

    // ***********************************************************
    // next state
    // ***********************************************************
    always_comb
    begin
        d        = q;
        // contacts bounce; only a level stable for a while is taken
        d.s1     = raw; // R18
        d.s2     = q.s1;
        for (int i = 0; i < NIN; i++)
        begin
            if (q.s2[i] != q.deb[i])
            begin
                d.dcnt[i] = q.dcnt[i] + 1'b1;
                if (q.dcnt[i] == DEB_W'(DEB_CYCLES - 1)) // R18
                begin
                    d.deb[i]  = q.s2[i];
                    d.dcnt[i] = '0;
                end
            end
            else
            begin
                d.dcnt[i] = '0;
            end
        end
        // safety lines skip the debounce so they act at once
        d.x1     = {link.door_open, link.emergency_stop};
        d.x2     = q.x1;
        d.pcut   = q.x2[0]; // R11
        d.shut   = q.x2[1]; // R12

        d.tick   = 1'b0;
        if (q.div == DIV_W'(P_MS_CYCLES - 1))
        begin
            d.div  = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.div = q.div + 1'b1;
        end

        rem      = q.deb[IN_REM]; // R1
        d.accept = rem;

        // ***********************************************************
        // high voltage with re-enable lockout
        // ***********************************************************
        d.hv = rem && q.deb[IN_HV] && q.lock == '0 && !q.x2[0]; // R2
        if (q.hv && !d.hv)
        begin
            // one extra millisecond makes the wait strictly longer
            d.lock = 12'(HV_LOCK_MS + 1); // R3
        end
        else if (q.tick && q.lock != '0)
        begin
            d.lock = q.lock - 1'b1; // R3
        end

        // ***********************************************************
        // fault alarm; a new fault wins over a reset in the same cycle
        // ***********************************************************
        if (i_fault_cause)
        begin
            d.alarm = 1'b1; // R4
        end
        else if (rem && q.deb[IN_FRST])
        begin
            d.alarm = 1'b0; // R4
        end

        d.ready = q.hv && i_cap_charged; // R16

        // ***********************************************************
        // fire and stop
        // ***********************************************************
        fire_c   = rem && q.deb[IN_FIRE];
        stop_c   = rem && q.deb[IN_STOP];
        d.fire_p = 1'b0;
        d.stop_p = 1'b0;
        if (fire_c)
        begin
            if (q.tick && q.close_ms != 8'hff)
            begin
                d.close_ms = q.close_ms + 1'b1;
            end
            // short gaps are refused rather than queued
            if (!q.fired && q.close_ms >= i_dip_min_ms // R5
                && q.open_ms >= 6'(FIRE_GAP_MS) // R6
                && stop_c && q.hv && !q.alarm) // R7
            begin
                d.fire_p = 1'b1; // R5
                d.fired  = 1'b1;
                d.firing = 1'b1;
            end
        end
        else
        begin
            d.close_ms = '0;
            d.fired    = 1'b0;
            if (q.fired || q.close_ms != '0)
            begin
                d.open_ms = '0;
            end
            else if (q.tick && q.open_ms != 6'h3f)
            begin
                d.open_ms = q.open_ms + 1'b1;
            end
        end
        if (q.firing && (!stop_c || i_output_done))
        begin
            d.firing = 1'b0;
            d.stop_p = !stop_c && i_repeat_on; // R8
        end

        // ***********************************************************
        // completion contact, retriggered by each flash
        // ***********************************************************
        if (i_lamp_flash)
        begin
            d.end_ms = 6'(END_MS); // R15
        end
        else if (q.tick && q.end_ms != '0)
        begin
            d.end_ms = q.end_ms - 1'b1;
        end
        d.end_c = d.end_ms != '0; // R15

        d.guide = rem && q.deb[IN_GUIDE]; // R9
        d.beam  = rem ? q.deb[IN_BSEL+1:IN_BSEL] : 2'h0; // R10
        if (rem)
        begin
            d.sch = q.deb[IN_SCH+SCH_W-1:IN_SCH]; // R14
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            q         <= '0;
            q.open_ms <= 6'(FIRE_GAP_MS);
        end
        else
        begin
            q <= d;
        end
    end

    // ***********************************************************
    // outputs
    // ***********************************************************
    assign link.ready_contact   = q.ready; // R16
    assign link.hv_on_contact   = q.hv;
    assign link.trouble_contact = !q.alarm; // R17
    assign link.end_contact     = q.end_c;
    assign link.accept_contact  = q.accept;
    assign o_hv_enable      = q.hv;
    assign o_fire           = q.fire_p;
    assign o_firing         = q.firing;
    assign o_stop_output    = q.stop_p;
    assign o_alarm          = q.alarm;
    assign o_guide_beam     = q.guide;
    assign o_beam_unit      = q.beam;
    assign o_schedule       = q.sch;
    assign o_main_power_cut = q.pcut;
    assign o_shutter_close  = q.shut;
endmodule
`default_nettype wire

// ### edcp_pkg.sv
// Operation
// R1: external inputs honoured only while remote_enable_input closed; emergency_stop and door_open act regardless
// R2: high voltage follows its request contact
// R3: re-enable refused until over 2 s after off
// R4: alarm latches; cleared by reset contact, cause gone
// R5: fire closure, held for DIP minimum, fires once
// R6: controller leaves fire open 40 ms between closures
// R7: controller keeps stop contact closed while firing
// R8: stop contact ends repeat output; held 1 ms
// R9: guide beam follows its request contact
// R10: beam-path select contacts pick delivery unit
// R11: emergency stop cuts main power
// R12: door open closes branch shutter at once
// R13: schedules preprogrammed; controller only selects and triggers
// R14: schedule number from five weighted select contacts
// R15: completion contact closes 50 ms per lamp flash
// R16: ready contact only with voltage on and charged
// R17: fault contact opens until fault reset
// R18: contact inputs synchronised and debounced first; emergency_stop and door_open only synchronised
`default_nettype none
package edcp_pkg;
    // ***********************************************************
    // time base
    // ***********************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 17;
    localparam int HV_LOCK_MS    = 2000;
    localparam int FIRE_GAP_MS   = 40;
    localparam int STOP_MIN_MS   = 1;
    localparam int END_MS        = 50;
    localparam int DEB_CYCLES    = 16;
    localparam int DEB_W         = 5;
    // ***********************************************************
    // contact input positions
    // ***********************************************************
    localparam int SCH_W    = 5;
    localparam int IN_REM   = 0;
    localparam int IN_HV    = 1;
    localparam int IN_FRST  = 2;
    localparam int IN_FIRE  = 3;
    localparam int IN_STOP  = 4;
    localparam int IN_GUIDE = 5;
    localparam int IN_BSEL  = 6;
    localparam int IN_SCH   = 8;
    localparam int NIN      = 13;
endpackage
`default_nettype wire

// ### edcp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface edcp_link_if;
    // contacts: 1 means closed to common
    logic                       remote_enable_input;
    logic                       high_voltage_request;
    logic                       fault_reset;
    logic                       fire_request;
    logic                       stop_contact;
    logic                       guide_request;
    logic [1:0]                 beam_select;
    logic [edcp_pkg::SCH_W-1:0] schedule_select;
    logic                       emergency_stop;
    logic                       door_open;
    // relay outputs of the device: 1 means closed
    logic                       ready_contact;
    logic                       hv_on_contact;
    logic                       trouble_contact;
    logic                       end_contact;
    logic                       accept_contact;

    modport device
    (
        input  remote_enable_input, high_voltage_request, fault_reset,
        input  fire_request, stop_contact, guide_request, beam_select,
        input  schedule_select, emergency_stop, door_open,
        output ready_contact, hv_on_contact, trouble_contact,
        output end_contact, accept_contact
    );
    modport controller
    (
        output remote_enable_input, high_voltage_request, fault_reset,
        output fire_request, stop_contact, guide_request, beam_select,
        output schedule_select, emergency_stop, door_open,
        input  ready_contact, hv_on_contact, trouble_contact,
        input  end_contact, accept_contact
    );
endinterface
`default_nettype wire

// ### edcp_controller.sv
`timescale 1ns/1ns
`default_nettype none
module edcp_controller #(
    parameter int P_MS_CYCLES = edcp_pkg::MS_CYCLES
)(
    input  wire logic                       i_clk,
    input  wire logic                       i_arst_n,
    edcp_link_if.controller                 link,
    input  wire logic                       i_remote,
    input  wire logic                       i_hv,
    input  wire logic                       i_fault_reset,
    input  wire logic                       i_guide,
    input  wire logic [1:0]                 i_beam_select,
    input  wire logic [edcp_pkg::SCH_W-1:0] i_schedule,
    input  wire logic                       i_estop,
    input  wire logic                       i_door_open,
    input  wire logic                       i_fire,
    input  wire logic [7:0]                 i_close_ms,
    input  wire logic                       i_stop,
    output logic                            o_busy,
    output logic                            o_ready,
    output logic                            o_hv_on,
    output logic                            o_trouble,
    output logic                            o_end,
    output logic                            o_accept
);
    import edcp_pkg::*;

    typedef enum logic [1:0] {F_IDLE, F_CLOSE, F_GAP} edcp_fire_t;

    typedef struct packed {
        logic [4:0]       s1;
        logic [4:0]       s2;
        logic [DIV_W-1:0] div;
        logic             tick;
        edcp_fire_t       fst;
        logic [7:0]       fcnt;
        logic [1:0]       scnt;
        logic             stop_open;
        logic [14:0]      pins;
        logic             busy;
    } edcp_ctl_state_t;

    edcp_ctl_state_t q;
    edcp_ctl_state_t d;

    // ***********************************************************
    // next state
    // ***********************************************************
    always_comb
    begin
        d      = q;
        // trouble kept inverted so the reset value reads as no alarm
        d.s1   = {link.accept_contact, link.end_contact,
                  !link.trouble_contact, link.hv_on_contact,
                  link.ready_contact};
        d.s2   = q.s1;
        d.tick = 1'b0;
        if (q.div == DIV_W'(P_MS_CYCLES - 1))
        begin
            d.div  = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.div = q.div + 1'b1;
        end
        // fire closure held past the minimum, then a guarded gap
        unique case (q.fst)
            F_IDLE:
            begin
                if (i_fire)
                begin
                    d.fst  = F_CLOSE;
                    d.fcnt = '0;
                end
            end
            F_CLOSE:
            begin
                if (q.tick)
                begin
                    d.fcnt = q.fcnt + 1'b1;
                end
                // one extra tick covers the partial first millisecond
                if (q.tick && q.fcnt > i_close_ms) // R5
                begin
                    d.fst  = F_GAP;
                    d.fcnt = '0;
                end
            end
            F_GAP:
            begin
                if (q.tick)
                begin
                    d.fcnt = q.fcnt + 1'b1;
                end
                if (q.tick && q.fcnt > 8'(FIRE_GAP_MS)) // R6
                begin
                    d.fst = F_IDLE;
                end
            end
        endcase
        // stop is a break of the normally closed stop contact
        if (i_stop && !q.stop_open)
        begin
            d.stop_open = 1'b1;
            d.scnt      = '0;
        end
        else if (q.stop_open && q.tick)
        begin
            d.scnt = q.scnt + 1'b1;
            if (q.scnt > 2'(STOP_MIN_MS)) // R8
            begin
                d.stop_open = 1'b0;
            end
        end
        d.busy = (d.fst != F_IDLE);
        // schedules only selected here, never programmed
        d.pins = {i_door_open, i_estop, i_schedule, i_beam_select,
                  i_guide, !d.stop_open, // R7
                  d.fst == F_CLOSE, i_fault_reset, i_hv, i_remote}; // R13
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            q     <= '0;
            q.fst <= F_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.remote_enable_input  = q.pins[0];
    assign link.high_voltage_request = q.pins[1];
    assign link.fault_reset          = q.pins[2];
    assign link.fire_request         = q.pins[3];
    assign link.stop_contact         = q.pins[4];
    assign link.guide_request        = q.pins[5];
    assign link.beam_select          = q.pins[7:6];
    assign link.schedule_select      = q.pins[12:8];
    assign link.emergency_stop       = q.pins[13];
    assign link.door_open            = q.pins[14];
    assign o_busy    = q.busy;
    assign o_ready   = q.s2[0];
    assign o_hv_on   = q.s2[1];
    assign o_trouble = q.s2[2];
    assign o_end     = q.s2[3];
    assign o_accept  = q.s2[4];
endmodule
`default_nettype wire

// ### edcp_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module edcp_link_properties #(
    parameter int P_MS_CYCLES = 20
)(
    input wire logic       i_clk,
    input wire logic       i_arst_n,
    input wire logic       remote_enable_input,
    input wire logic       high_voltage_request,
    input wire logic       fault_reset,
    input wire logic       fire_request,
    input wire logic       stop_contact,
    input wire logic       guide_request,
    input wire logic [1:0] beam_select,
    input wire logic [4:0] schedule_select,
    input wire logic       emergency_stop,
    input wire logic       door_open,
    input wire logic       ready_contact,
    input wire logic       hv_on_contact,
    input wire logic       trouble_contact,
    input wire logic       end_contact,
    input wire logic       accept_contact
);
    localparam int LOCK = 2000 * P_MS_CYCLES;
    localparam int GAP  = 40 * P_MS_CYCLES;
    localparam int E_LO = 49 * P_MS_CYCLES;
    localparam int E_HI = 51 * P_MS_CYCLES;
    // ***********************************************************
    // run lengths of contact states
    // ***********************************************************
    // saturating, so a long idle stretch never wraps into a short one
    logic [19:0] fire_len_q, gap_len_q, stop_len_q;
    logic [19:0] off_len_q, end_len_q, fr_open_q;

    function automatic logic [19:0] run(input logic on, input logic [19:0] n);
        return on ? ((n == 20'hfffff) ? n : n + 20'h00001) : 20'h00000;
    endfunction

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fire_len_q <= 20'h00000;
            gap_len_q  <= 20'hfffff;
            stop_len_q <= 20'hfffff;
            off_len_q  <= 20'hfffff;
            end_len_q  <= 20'h00000;
            fr_open_q  <= 20'hfffff;
        end
        else
        begin
            fire_len_q <= run(fire_request, fire_len_q);
            gap_len_q  <= run(!fire_request, gap_len_q);
            stop_len_q <= run(!stop_contact, stop_len_q);
            off_len_q  <= run(!hv_on_contact, off_len_q);
            end_len_q  <= run(end_contact, end_len_q);
            fr_open_q  <= run(!fault_reset, fr_open_q);
        end
    end
    // ***********************************************************
    // properties
    // ***********************************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    chk_remote_gates: assert property ($fell(remote_enable_input) |->
        ##[1:30] !accept_contact && !hv_on_contact)
        else $error("contacts held after remote opened");
    chk_hv_follows: assert property ($fell(high_voltage_request) &&
        remote_enable_input |-> ##[1:30] !hv_on_contact)
        else $error("high voltage stayed on");
    chk_hv_lockout: assert property ($rose(hv_on_contact) |->
        off_len_q >= LOCK) else $error("high voltage back too soon");
    chk_alarm_held: assert property ($rose(trouble_contact) |->
        fr_open_q < 24) else $error("alarm cleared without reset");
    chk_fire_hold: assert property ($fell(fire_request) |->
        fire_len_q >= P_MS_CYCLES) else $error("fire closure too short");
    chk_fire_gap: assert property ($rose(fire_request) |->
        gap_len_q >= GAP) else $error("fire open gap too short");
    chk_fire_stop: assert property ($rose(fire_request) |->
        stop_contact) else $error("fire with stop open");
    chk_stop_hold: assert property ($rose(stop_contact) |->
        stop_len_q >= P_MS_CYCLES) else $error("stop too short");
    chk_end_width: assert property ($fell(end_contact) |->
        end_len_q >= E_LO && end_len_q <= E_HI)
        else $error("end contact width wrong");
    chk_ready_hv: assert property ($rose(ready_contact) |->
        hv_on_contact) else $error("ready without high voltage");
endmodule
`default_nettype wire

// ### tb_external_discrete_control_port.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_external_discrete_control_port;
    import edcp_pkg::*;
    localparam int P = 20;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_remote = 1'b0, i_hv = 1'b0;
    logic i_fault_reset = 1'b0, i_guide = 1'b0, i_estop = 1'b0;
    logic i_door_open = 1'b0, i_fire = 1'b0, i_stop = 1'b0;
    logic [1:0] i_beam_select = 2'h0;
    logic [4:0] i_schedule = 5'h00;
    logic [7:0] i_close_ms = 8'h03, dip_min_ms = 8'h02;
    logic fault_cause = 1'b0, cap_charged = 1'b0, repeat_on = 1'b1;
    logic output_done = 1'b0, lamp_flash = 1'b0;
    logic o_busy, o_ready, o_hv_on, o_trouble, o_end, o_accept;
    logic o_hv_enable, o_fire, o_firing, o_stop_output, o_alarm;
    logic o_guide_beam, o_main_power_cut, o_shutter_close;
    logic [1:0] o_beam_unit;
    logic [4:0] o_schedule;
    int num_errors = 0, comparisons = 0, fire_cnt = 0, stop_cnt = 0;

    edcp_link_if link();
    edcp_controller #(.P_MS_CYCLES(P)) u_edcp_controller (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .link(link), .i_remote(i_remote), .i_hv(i_hv),
        .i_fault_reset(i_fault_reset), .i_guide(i_guide),
        .i_beam_select(i_beam_select), .i_schedule(i_schedule),
        .i_estop(i_estop), .i_door_open(i_door_open), .i_fire(i_fire),
        .i_close_ms(i_close_ms), .i_stop(i_stop), .o_busy(o_busy),
        .o_ready(o_ready), .o_hv_on(o_hv_on), .o_trouble(o_trouble),
        .o_end(o_end), .o_accept(o_accept));
    edcp_device #(.P_MS_CYCLES(P)) u_edcp_device (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .link(link), .i_fault_cause(fault_cause),
        .i_cap_charged(cap_charged), .i_dip_min_ms(dip_min_ms),
        .i_repeat_on(repeat_on), .i_output_done(output_done),
        .i_lamp_flash(lamp_flash), .o_hv_enable(o_hv_enable),
        .o_fire(o_fire), .o_firing(o_firing), .o_stop_output(o_stop_output),
        .o_alarm(o_alarm), .o_guide_beam(o_guide_beam),
        .o_beam_unit(o_beam_unit), .o_schedule(o_schedule),
        .o_main_power_cut(o_main_power_cut),
        .o_shutter_close(o_shutter_close));
    edcp_link_properties #(.P_MS_CYCLES(P)) u_edcp_link_properties (
        .i_clk(i_clk), .i_arst_n(i_arst_n),
        .remote_enable_input(link.remote_enable_input),
        .high_voltage_request(link.high_voltage_request),
        .fault_reset(link.fault_reset), .fire_request(link.fire_request),
        .stop_contact(link.stop_contact), .guide_request(link.guide_request),
        .beam_select(link.beam_select),
        .schedule_select(link.schedule_select),
        .emergency_stop(link.emergency_stop), .door_open(link.door_open),
        .ready_contact(link.ready_contact),
        .hv_on_contact(link.hv_on_contact),
        .trouble_contact(link.trouble_contact),
        .end_contact(link.end_contact),
        .accept_contact(link.accept_contact));
    // ***********************************************************
    // clock, pulse counters, helpers
    // ***********************************************************
    initial
    begin
        forever #5 i_clk = ~i_clk;
    end
    always @(negedge i_clk)
    begin
        if (o_fire === 1'b1) fire_cnt++;
        if (o_stop_output === 1'b1) stop_cnt++;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < 3000)
        begin
            tick(1);
            n++;
        end
        `CHK(o_busy, 1'b0)
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ***********************************************************
    // tests
    // ***********************************************************
    initial
    begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_arst_n = 1'b1;
        i_hv = 1'b1;
        tick(40);
        `CHK(o_hv_enable, 1'b0)
        `CHK(o_accept, 1'b0)
        `CHK(o_trouble, 1'b0)
        i_remote = 1'b1;
        tick(40);
        `CHK(o_accept, 1'b1)
        `CHK(o_hv_on, 1'b1)
        `CHK(o_ready, 1'b0)
        cap_charged = 1'b1;
        tick(10);
        `CHK(o_ready, 1'b1)
        for (int k = 0; k < 32; k++)
        begin
            i_schedule = 5'(k);
            i_beam_select = 2'(k);
            i_guide = k[0];
            tick(40);
            `CHK(o_schedule, 5'(k))
            `CHK(o_beam_unit, 2'(k))
            `CHK(o_guide_beam, k[0])
        end
        // a 4..5 ms closure against a 2 ms minimum, stopped mid-output
        i_fire = 1'b1;
        tick(1);
        i_fire = 1'b0;
        tick(90);
        `CHK(fire_cnt, 1)
        `CHK(o_firing, 1'b1)
        i_stop = 1'b1;
        tick(1);
        i_stop = 1'b0;
        tick(40);
        `CHK(stop_cnt, 1)
        `CHK(o_firing, 1'b0)
        wait_idle;
        // closure shorter than the minimum gives no output
        dip_min_ms = 8'h05;
        i_close_ms = 8'h00;
        i_fire = 1'b1;
        tick(1);
        i_fire = 1'b0;
        wait_idle;
        `CHK(fire_cnt, 1)
        // output done ends firing; stop closed, so no stop pulse
        dip_min_ms = 8'h02;
        i_close_ms = 8'h03;
        repeat_on = 1'b0;
        i_fire = 1'b1;
        tick(1);
        i_fire = 1'b0;
        tick(90);
        `CHK(fire_cnt, 2)
        `CHK(o_firing, 1'b1)
        output_done = 1'b1;
        tick(1);
        output_done = 1'b0;
        tick(2);
        `CHK(o_firing, 1'b0)
        `CHK(stop_cnt, 1)
        wait_idle;
        // reset closed while the cause persists must not clear it
        fault_cause = 1'b1;
        tick(100);
        `CHK(o_alarm, 1'b1)
        `CHK(o_trouble, 1'b1)
        i_fault_reset = 1'b1;
        tick(40);
        `CHK(o_alarm, 1'b1)
        fault_cause = 1'b0;
        tick(10);
        i_fault_reset = 1'b0;
        tick(10);
        `CHK(o_alarm, 1'b0)
        `CHK(o_trouble, 1'b0)
        lamp_flash = 1'b1;
        tick(1);
        lamp_flash = 1'b0;
        tick(10);
        `CHK(o_end, 1'b1)
        tick(1040);
        `CHK(o_end, 1'b0)
        i_hv = 1'b0;
        tick(40);
        `CHK(o_hv_enable, 1'b0)
        i_hv = 1'b1;
        tick(100);
        `CHK(o_hv_enable, 1'b0)
        tick(40000);
        `CHK(o_hv_enable, 1'b1)
        i_estop = 1'b1;
        i_door_open = 1'b1;
        tick(10);
        `CHK(o_main_power_cut, 1'b1)
        `CHK(o_shutter_close, 1'b1)
        i_remote = 1'b0;
        tick(40);
        `CHK(o_accept, 1'b0)
        `CHK(o_hv_enable, 1'b0)
        wrap_up;
    end
    // whole run is about 46000 cycles
    initial
    begin
        repeat (60000) @(posedge i_clk);
        num_errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
